// ### core/irq_combiner_pkg.sv
package irq_combiner_pkg;

    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int SLOT_COUNT     = 3;
    localparam int LINES_PER_SLOT = 4;
    localparam int SOURCE_COUNT   = SLOT_COUNT * LINES_PER_SLOT;
    localparam int SLOT_IDX_W     = 2;

    // ---------------------------------------------------------------
    // Local bus
    // ---------------------------------------------------------------
    localparam int BUS_DATA_W = 32;
    localparam int BUS_ADDR_W = 3;

    localparam logic [BUS_ADDR_W-1:0] SLOT_INTERRUPT_PENDING_OFS = 3'h0;
    localparam logic [BUS_ADDR_W-1:0] SLOT_INTERRUPT_MASK_OFS    = 3'h4;

    localparam logic [SOURCE_COUNT-1:0] PENDING_RESET = 12'h000;
    localparam logic [SOURCE_COUNT-1:0] MASK_RESET    = 12'h000;
    localparam logic [BUS_DATA_W-1:0]   READ_IDLE     = 32'h0000_0000;

    // ---------------------------------------------------------------
    // Access sequencer
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_IDLE   = 2'b00,
        ACC_SETTLE = 2'b01,
        ACC_HOLD   = 2'b10
    } acc_state_t;

endpackage

// ### core/pci_slot_interrupt_combiner.sv
`timescale 1ns/1ps

// Function
// - Twelve active-low slot request lines accepted
// - One combined interrupt request to host
// - Registers answer only own chip select
// - Fixed slot priority, slot zero first
// - Shared line sets three unmasked pending bits
// - Pending register readable at offset zero
// - Pending bit map by slot, reset zero
// - Mask register read/write at offset four
// - Mask blocks pending set and output
// - Mask same map, one masks, reset zero
module pci_slot_interrupt_combiner
    import irq_combiner_pkg::*;
#(
    parameter int SLOTS = irq_combiner_pkg::SLOT_COUNT,
    parameter int LINES = irq_combiner_pkg::LINES_PER_SLOT
) (
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_i,
    input  wire logic [irq_combiner_pkg::SOURCE_COUNT-1:0] slot_req_n_i,
    input  wire logic                                   ctrl_chip_select_n_i,
    input  wire logic                                   bus_write_n_i,
    input  wire logic [irq_combiner_pkg::BUS_ADDR_W-1:0] bus_addr_i,
    input  wire logic [irq_combiner_pkg::BUS_DATA_W-1:0] bus_data_i,
    output logic      [irq_combiner_pkg::BUS_DATA_W-1:0] bus_data_o,
    output logic                                        bus_data_oe_o,
    output logic                                        combined_irq_out_n_o,
    output logic      [irq_combiner_pkg::SLOT_IDX_W-1:0] top_slot_o
);
    import irq_combiner_pkg::*;

    localparam int SRC = SLOTS * LINES;
    localparam int BUS_IN_W = 2 + BUS_ADDR_W + BUS_DATA_W;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [SRC-1:0]        req_n_s;
    logic [BUS_IN_W-1:0]   bus_raw;
    logic [BUS_IN_W-1:0]   bus_s;
    logic                  cs_active;
    logic                  wr_active;
    logic [BUS_ADDR_W-1:0] addr_s;
    logic [BUS_DATA_W-1:0] data_s;

    sync_stage #(
        .WIDTH     (SRC),
        .RESET_VAL ({SRC{1'b1}})
    ) u_req_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (slot_req_n_i),
        .sync_o  (req_n_s)
    );

    assign bus_raw = {ctrl_chip_select_n_i, bus_write_n_i, bus_addr_i, bus_data_i};

    // Strobes idle high; address and data idle zero
    sync_stage #(
        .WIDTH     (BUS_IN_W),
        .RESET_VAL ({2'b11, {(BUS_IN_W-2){1'b0}}})
    ) u_bus_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (bus_raw),
        .sync_o  (bus_s)
    );

    assign cs_active = ~bus_s[BUS_IN_W-1];
    assign wr_active = ~bus_s[BUS_IN_W-2];
    assign addr_s    = bus_s[BUS_DATA_W +: BUS_ADDR_W];
    assign data_s    = bus_s[BUS_DATA_W-1:0];

    // ---------------------------------------------------------------
    // Shared line routing
    // ---------------------------------------------------------------
    // Slot s pin p lands on shared line (p + s) mod LINES, so every
    // shared line carries one pin of each slot.
    logic [LINES-1:0] shared_line;
    logic [SRC-1:0]   line_hit;

    always_comb begin
        shared_line = '0;
        for (int s = 0; s < SLOTS; s++) begin
            for (int p = 0; p < LINES; p++) begin
                if (!req_n_s[s*LINES + p]) begin
                    shared_line[(p + s) % LINES] = 1'b1;
                end
            end
        end
    end

    // One asserted shared line marks all its slot candidates
    always_comb begin
        line_hit = '0;
        for (int s = 0; s < SLOTS; s++) begin
            for (int p = 0; p < LINES; p++) begin
                line_hit[s*LINES + p] = shared_line[(p + s) % LINES];
            end
        end
    end

    // ---------------------------------------------------------------
    // Access sequencer
    // ---------------------------------------------------------------
    // Address and data pass the same two flops as the strobes, but a
    // skewed pin can still land one cycle late; SETTLE waits that out.
    acc_state_t            state;
    acc_state_t            next_state;
    logic                  do_write;
    logic                  do_read;
    logic [BUS_ADDR_W-1:0] acc_addr;
    logic [BUS_ADDR_W-1:0] next_acc_addr;
    logic                  acc_is_read;
    logic                  next_acc_is_read;
    logic [BUS_ADDR_W-1:0] sel_addr;

    always_comb begin
        next_state = state;
        do_write   = 1'b0;
        do_read    = 1'b0;
        case (state)
            ACC_IDLE: begin
                if (cs_active) begin
                    next_state = ACC_SETTLE;
                end
            end
            ACC_SETTLE: begin
                if (!cs_active) begin
                    next_state = ACC_IDLE;
                end else begin
                    do_write   = wr_active;
                    do_read    = ~wr_active;
                    next_state = ACC_HOLD;
                end
            end
            ACC_HOLD: begin
                do_read = cs_active & acc_is_read;
                if (!cs_active) begin
                    next_state = ACC_IDLE;
                end
            end
            default: begin
                next_state = ACC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ACC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ---------------------------------------------------------------
    // Access capture
    // ---------------------------------------------------------------
    // Taken once in SETTLE: a held select keeps reading the same
    // register even if the address pins wander afterwards.
    always_comb begin
        next_acc_addr    = acc_addr;
        next_acc_is_read = acc_is_read;
        if (state == ACC_SETTLE && cs_active) begin
            next_acc_addr    = addr_s;
            next_acc_is_read = ~wr_active;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_addr    <= '0;
            acc_is_read <= 1'b0;
        end else begin
            acc_addr    <= next_acc_addr;
            acc_is_read <= next_acc_is_read;
        end
    end

    // ---------------------------------------------------------------
    // Mask and pending registers
    // ---------------------------------------------------------------
    logic [SRC-1:0] mask;
    logic [SRC-1:0] pending;
    logic [SRC-1:0] next_mask;
    logic [SRC-1:0] next_pending;
    logic [SRC-1:0] clear_bits;
    logic           hit_pending;
    logic           hit_mask;

    // SETTLE decodes the pins, HOLD the captured copy
    assign sel_addr    = (state == ACC_HOLD) ? acc_addr : addr_s;
    assign hit_pending = (sel_addr == SLOT_INTERRUPT_PENDING_OFS);
    assign hit_mask    = (sel_addr == SLOT_INTERRUPT_MASK_OFS);

    always_comb begin
        next_mask  = mask;
        clear_bits = '0;
        if (do_write && hit_mask) begin
            next_mask = data_s[SRC-1:0];
        end
        // Write one to clear lets software drop the false candidates
        if (do_write && hit_pending) begin
            clear_bits = data_s[SRC-1:0];
        end
        // A new request in the clearing cycle survives: set wins
        next_pending = (pending & ~clear_bits) | (line_hit & ~mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask    <= MASK_RESET;
            pending <= PENDING_RESET;
        end else begin
            mask    <= next_mask;
            pending <= next_pending;
        end
    end

    // ---------------------------------------------------------------
    // Read data and data pin drive
    // ---------------------------------------------------------------
    logic [BUS_DATA_W-1:0] rd_data;
    logic [BUS_DATA_W-1:0] next_rd_data;
    logic                  drive;
    logic                  next_drive;

    // Unmapped offsets read zero but still drive, so the host never
    // latches a floating bus
    always_comb begin
        next_rd_data = READ_IDLE;
        next_drive   = do_read;
        if (do_read) begin
            if (hit_pending) begin
                next_rd_data = {{(BUS_DATA_W-SRC){1'b0}}, pending};
            end else if (hit_mask) begin
                next_rd_data = {{(BUS_DATA_W-SRC){1'b0}}, mask};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data <= READ_IDLE;
            drive   <= 1'b0;
        end else begin
            rd_data <= next_rd_data;
            drive   <= next_drive;
        end
    end

    assign bus_data_o    = rd_data;
    assign bus_data_oe_o = drive;

    // ---------------------------------------------------------------
    // Combined request and slot priority
    // ---------------------------------------------------------------
    logic                  any_live;
    logic [SLOT_IDX_W-1:0] win_slot;
    logic                  irq;
    logic                  next_irq;
    logic [SLOT_IDX_W-1:0] top_slot;
    logic [SLOT_IDX_W-1:0] next_top_slot;
    logic [SRC-1:0]        live_src;

    // Pending and unmasked: the only sources allowed to raise the output
    assign live_src = pending & ~mask;

    slot_priority #(
        .SLOTS (SLOTS),
        .LINES (LINES),
        .IDX_W (SLOT_IDX_W)
    ) u_prio (
        .active_i (live_src),
        .any_o    (any_live),
        .slot_o   (win_slot)
    );

    // Slot index is advisory; the single output carries no priority
    always_comb begin
        next_irq      = any_live;
        next_top_slot = win_slot;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq      <= 1'b0;
            top_slot <= '0;
        end else begin
            irq      <= next_irq;
            top_slot <= next_top_slot;
        end
    end

    assign combined_irq_out_n_o = ~irq;
    assign top_slot_o           = top_slot;

endmodule

// ### core/slot_priority.sv
`timescale 1ns/1ps

module slot_priority #(
    parameter int SLOTS  = 3,
    parameter int LINES  = 4,
    parameter int IDX_W  = 2
) (
    input  wire logic [SLOTS*LINES-1:0] active_i,
    output logic                        any_o,
    output logic      [IDX_W-1:0]       slot_o
);

    // ---------------------------------------------------------------
    // Fixed priority: lowest slot number wins
    // ---------------------------------------------------------------
    always_comb begin
        any_o  = 1'b0;
        slot_o = '0;
        for (int s = SLOTS - 1; s >= 0; s--) begin
            if (|active_i[s*LINES +: LINES]) begin
                any_o  = 1'b1;
                slot_o = IDX_W'(s);
            end
        end
    end

endmodule

// ### core/sync_stage.sv
`timescale 1ns/1ps

module sync_stage #(
    parameter int              WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // ---------------------------------------------------------------
    // Two-flop synchroniser; first stage feeds only the second
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_meta = async_i;
        next_sync = meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta   <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            meta   <= next_meta;
            sync_o <= next_sync;
        end
    end

endmodule

// ### verification/irq_combiner_sva.sv
`timescale 1ns/1ps

module irq_combiner_sva #(
    parameter int SLOTS = 3,
    parameter int LINES = 4
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [11:0] slot_req_n_i,
    input wire logic        ctrl_chip_select_n_i,
    input wire logic        bus_write_n_i,
    input wire logic [2:0]  bus_addr_i,
    input wire logic [31:0] bus_data_i,
    input wire logic [31:0] bus_data_o,
    input wire logic        bus_data_oe_o,
    input wire logic        combined_irq_out_n_o,
    input wire logic [1:0]  top_slot_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ---------------------------------------------------------------
    // Bus side
    // ---------------------------------------------------------------
    AST_READ_ANSWER: assert property ($fell(ctrl_chip_select_n_i) && bus_write_n_i
        |-> ##[3:5] bus_data_oe_o) else $error("read got no answer");
    AST_DRIVE_NEEDS_CS: assert property ($rose(bus_data_oe_o)
        |-> !$past(ctrl_chip_select_n_i, 3) && $past(bus_write_n_i, 3))
        else $error("data driven without a read");
    AST_IDLE_RELEASE: assert property (ctrl_chip_select_n_i [*6]
        |-> !bus_data_oe_o) else $error("data pins held while deselected");
    AST_WRITE_NO_DRIVE: assert property ((!ctrl_chip_select_n_i && !bus_write_n_i) [*4]
        |-> !bus_data_oe_o) else $error("data driven during write");
    AST_DATA_IDLE_ZERO: assert property (!bus_data_oe_o
        |-> bus_data_o == 32'h0) else $error("read data not zero when idle");
    AST_UPPER_ZERO: assert property (bus_data_o[31:12] == 20'h0)
        else $error("upper read bits not zero");

    // ---------------------------------------------------------------
    // Interrupt side
    // ---------------------------------------------------------------
    AST_QUIET_NO_SLOT: assert property (combined_irq_out_n_o
        |-> top_slot_o == 2'h0) else $error("slot shown without request");
    AST_SLOT_RANGE: assert property (top_slot_o < SLOTS)
        else $error("slot index out of range");
    AST_RESET_QUIET: assert property ($past(rst_i)
        |-> combined_irq_out_n_o && !bus_data_oe_o) else $error("outputs busy after reset");

    cover property ($rose(bus_data_oe_o));
    cover property ($fell(combined_irq_out_n_o));
    cover property (top_slot_o == 2'h2);
endmodule

bind pci_slot_interrupt_combiner irq_combiner_sva #(.SLOTS(SLOTS), .LINES(LINES)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .slot_req_n_i(slot_req_n_i),
    .ctrl_chip_select_n_i(ctrl_chip_select_n_i), .bus_write_n_i(bus_write_n_i),
    .bus_addr_i(bus_addr_i), .bus_data_i(bus_data_i), .bus_data_o(bus_data_o),
    .bus_data_oe_o(bus_data_oe_o), .combined_irq_out_n_o(combined_irq_out_n_o),
    .top_slot_o(top_slot_o));

// ### verification/pci_slot_interrupt_combiner_test.sv
`timescale 1ns/1ps

module pci_slot_interrupt_combiner_test;
    import irq_combiner_pkg::*;

    localparam logic [2:0] PEND = SLOT_INTERRUPT_PENDING_OFS;
    localparam logic [2:0] MASK = SLOT_INTERRUPT_MASK_OFS;

    logic        clk_i;
    logic        rst_i;
    logic        cs_n;
    logic        wr_n;
    logic [2:0]  addr;
    logic [31:0] wdata;
    logic [11:0] raise;
    logic [11:0] req_n;
    logic [31:0] rdata;
    logic        oe;
    logic        irq_n;
    logic [1:0]  top;
    logic        oe_seen = 1'b0;
    logic [31:0] exp_q[$];
    int          n_fail = 0;
    int          checks = 0;
    int          cycles = 0;

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    slot_cards u_slot_cards (.clk_i(clk_i), .raise_i(raise), .slot_req_n_o(req_n));

    pci_slot_interrupt_combiner u_pci_slot_interrupt_combiner (
        .clk_i(clk_i), .rst_i(rst_i), .slot_req_n_i(req_n), .ctrl_chip_select_n_i(cs_n),
        .bus_write_n_i(wr_n), .bus_addr_i(addr), .bus_data_i(wdata), .bus_data_o(rdata),
        .bus_data_oe_o(oe), .combined_irq_out_n_o(irq_n), .top_slot_o(top));

    // ---------------------------------------------------------------
    // Checking and reporting
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic final_report;
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic done(input string t);
        $display("test %s finished", t);
    endtask

    // One access per select; reads are held until the data pins turn on
    task automatic acc(input logic w, input logic [2:0] a, input logic [31:0] d,
                       input logic [31:0] e);
        int n;
        n = 0;
        cs_n  <= 1'b0;
        wr_n  <= ~w;
        addr  <= a;
        wdata <= d;
        if (!w) exp_q.push_back(e);
        do begin
            @(posedge clk_i);
            n++;
        end while ((w ? n < 5 : oe !== 1'b1) && n < 20);
        if (n >= 20) chk(32'h1, 32'h0, "no read answer");
        cs_n  <= 1'b1;
        wdata <= ~d;
        repeat (5) @(posedge clk_i);
    endtask

    always @(posedge clk_i) begin
        if (oe === 1'b1 && !oe_seen) begin
            chk(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hx, "read data");
        end
        oe_seen <= (oe === 1'b1);
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            final_report();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        int          p;
        logic [31:0] e;
        logic [31:0] m;
        rst_i = 1'b1;
        cs_n  = 1'b1;
        wr_n  = 1'b1;
        addr  = 3'h0;
        wdata = 32'h0;
        raise = 12'h0;
        m     = $urandom(37);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        acc(1'b0, PEND, 32'h0, 32'h0);
        acc(1'b0, MASK, 32'h0, 32'h0);
        acc(1'b0, 3'h2, 32'h0, 32'h0);
        chk({31'h0, irq_n}, 32'h1, "irq idle");
        done("reset");
        m = $urandom();
        acc(1'b1, MASK, m, 32'h0);
        acc(1'b0, MASK, 32'h0, m & 32'hfff);
        acc(1'b1, MASK, 32'h0, 32'h0);
        done("mask access");
        for (int k = 0; k < 4; k++) begin
            for (int s = 0; s < 3; s++) begin
                p = 4 * s + (k - s + 4) % 4;
                e = 32'h0;
                for (int t = 0; t < 3; t++) e[4 * t + (k - t + 4) % 4] = 1'b1;
                raise[p] <= 1'b1;
                repeat (8) @(posedge clk_i);
                chk({31'h0, irq_n}, 32'h0, "irq low");
                chk({30'h0, top}, 32'h0, "top slot");
                raise <= 12'h0;
                repeat (4) @(posedge clk_i);
                acc(1'b0, PEND, 32'h0, e);
                acc(1'b1, PEND, e & ~(32'h1 << p), 32'h0);
                acc(1'b0, PEND, 32'h0, 32'h1 << p);
                acc(1'b1, PEND, 32'hffff_ffff, 32'h0);
                chk({31'h0, irq_n}, 32'h1, "irq cleared");
            end
        end
        done("shared lines");
        acc(1'b1, MASK, 32'hbff, 32'h0);
        raise <= 12'h001;
        repeat (8) @(posedge clk_i);
        chk({30'h0, top}, 32'h2, "priority");
        acc(1'b1, MASK, 32'hfff, 32'h0);
        raise <= 12'($urandom());
        repeat (8) @(posedge clk_i);
        chk({31'h0, irq_n}, 32'h1, "masked irq");
        raise <= 12'h0;
        repeat (4) @(posedge clk_i);
        acc(1'b0, PEND, 32'h0, 32'h400);
        acc(1'b1, PEND, 32'hfff, 32'h0);
        acc(1'b1, MASK, 32'h0, 32'h0);
        done("mask and priority");
        final_report();
    end
endmodule

// ### verification/slot_cards.sv
`timescale 1ns/1ps

module slot_cards (
    input  wire logic        clk_i,
    input  wire logic [11:0] raise_i,
    output logic      [11:0] slot_req_n_o
);
    logic [11:0] next_slot_req_n;

    // Released lines sit at the pull-up level
    always_comb begin
        next_slot_req_n = ~raise_i;
    end

    always_ff @(posedge clk_i) begin
        slot_req_n_o <= next_slot_req_n;
    end
endmodule
